//--- rtl/stm_map.svh
// register map, field positions, codes and reset values of the standard timer
// assumes: included by the package and the bench, by bare name
`ifndef STM_MAP_SVH
`define STM_MAP_SVH

// register port widths and counter width
`define STM_ADDR_W      3
`define STM_DATA_W      8
`define STM_CNT_W       10

// register offsets
`define STM_OFS_CTRL0   3'h0
`define STM_OFS_CTRL1   3'h1
`define STM_OFS_CNT_LO  3'h2
`define STM_OFS_CNT_HI  3'h3
`define STM_OFS_CMPA_LO 3'h4
`define STM_OFS_CMPA_HI 3'h5
`define STM_OFS_FLAGS   3'h6

// timer_control_zero fields
`define STM_C0_ON       3
`define STM_C0_P_HI     2
`define STM_C0_P_LO     0

// timer_control_one fields
`define STM_C1_MODE_HI  7
`define STM_C1_MODE_LO  6
`define STM_C1_IO_HI    5
`define STM_C1_IO_LO    4
`define STM_C1_OC       3
`define STM_C1_POL      2
`define STM_C1_DPX      1
`define STM_C1_CCLR     0

// flag register fields
`define STM_FL_A        0
`define STM_FL_P        1

// pin action codes
`define STM_IO_NONE     2'b00
`define STM_IO_LOW      2'b01
`define STM_IO_HIGH     2'b10
`define STM_IO_TOGGLE   2'b11
`define STM_IO_PWM      2'b10
`define STM_IO_PULSE    2'b11

// counting constants
`define STM_CNT_ZERO    10'h000
`define STM_CNT_ONE     10'h001
`define STM_P_ZERO      3'h0
`define STM_P_LSB       7'h00
`define STM_FULL_SPAN   11'h400
`define STM_SPAN_ONE    11'h001
`define STM_RST_BYTE    8'h00

`endif

//--- rtl/stm_pkg.sv
// types and shared arithmetic of the standard timer
// assumes: stm_map.svh is on the include path
package stm_pkg;
  `include "stm_map.svh"

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } tm_mode_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  typedef struct packed {
    logic                   on;
    logic                   on_d;
    logic [2:0]             cmpp;
    tm_mode_t               mode;
    logic [1:0]             io;
    logic                   oc;
    logic                   pol;
    logic                   dpx;
    logic                   cclr;
    logic [`STM_CNT_W-1:0]  cmpa;
    logic [`STM_CNT_W-1:0]  cnt;
    logic                   flag_a;
    logic                   flag_p;
    logic                   lvl;
    logic                   pin;
    logic                   oe;
    logic [`STM_DATA_W-1:0] rdata;
  } tm_state_t;

  // span of the 3-bit compare-P setting in clocks
  function automatic logic [10:0] p_span(input logic [2:0] p);
    p_span = (p == `STM_P_ZERO) ? `STM_FULL_SPAN : {1'b0, p, `STM_P_LSB};
  endfunction : p_span

endpackage : stm_pkg

//--- rtl/stm_edge_sync.sv
// three-stage synchroniser for the external trigger pin with rising-edge pulse
// assumes: pin is asynchronous to i_clk; output pulse lasts one enabled cycle
`timescale 1ns/1ps
`default_nettype none
module stm_edge_sync
  import stm_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // pin and event
  input  wire logic i_pin,
  output logic      o_rise
);

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // level moves only once stages two and three agree
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_rise = i_ce && (st_r.s2 == st_r.s3) && st_r.s3 && !st_r.lvl;

endmodule : stm_edge_sync
`default_nettype wire

//--- rtl/stm_match_unit.sv
// comparators A and P plus edge-aligned pwm period and duty decode
// assumes: counter and compare values come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module stm_match_unit
  import stm_pkg::*;
(
  // counter and settings
  input  wire logic [`STM_CNT_W-1:0] i_cnt,
  input  wire logic [`STM_CNT_W-1:0] i_cmpa,
  input  wire logic [2:0]            i_cmpp,
  input  wire logic                  i_dpx,
  // compare results
  output logic                       o_match_a,
  output logic                       o_match_p,
  output logic                       o_pwm_wrap,
  output logic                       o_pwm_active,
  output logic                       o_pwm_full
);

  logic [10:0] period;
  logic [10:0] duty;
  logic [10:0] cnt_w;

  always_comb begin
    cnt_w        = {1'b0, i_cnt};
    period       = i_dpx ? {1'b0, i_cmpa} : p_span(i_cmpp);  // RULE12 RULE13
    duty         = i_dpx ? p_span(i_cmpp) : {1'b0, i_cmpa};  // RULE12 RULE13
    // zero compare-A never matches, so the counter runs to 3ff
    o_match_a    = (i_cmpa != `STM_CNT_ZERO) && (i_cnt == i_cmpa);  // RULE6
    // compare-P only meets counter bits 9..7, at multiples of 128
    o_match_p    = (i_cmpp != `STM_P_ZERO) && (i_cnt == {i_cmpp, `STM_P_LSB});  // RULE22
    o_pwm_wrap   = (cnt_w == (period - `STM_SPAN_ONE));  // RULE17
    o_pwm_full   = (duty >= period);  // RULE14
    o_pwm_active = o_pwm_full || (cnt_w < duty);  // RULE14
  end

endmodule : stm_match_unit
`default_nettype wire

//--- rtl/stm_timer.sv
// 10-bit standard timer: compare match, timer, pwm and single pulse modes
// assumes: counter clock is I_CLK gated by I_CE; register port is synchronous
// Operation
// RULE1: counter readable, bits 9..8 high, rest zero
// RULE2: compare-A ten bits read/write, resets zero
// RULE3: mode 00 compare output, clear per select
// RULE4: select low: clear on P, both flags
// RULE5: select high: clear on A, only A flag
// RULE6: zero compare-A overflows, no A flag
// RULE7: software keeps compare-A nonzero in compare mode
// RULE8: pin moves only on A match flag
// RULE9: counter-on rise loads initial pin level
// RULE10: mode 11 counts like compare, pin unused
// RULE11: software selects pwm by mode and action
// RULE12: swap clear: period from P, duty A
// RULE13: swap set: period from A, duty P
// RULE14: duty at least period gives full duty
// RULE15: pwm raises both A and P flags; only the duty-side flag sets here
// RULE16: actions 00/01 force pin, pwm runs
// RULE17: pwm clear comes from period comparator only
// RULE18: mode 10 action 11 single pulse
// RULE19: trigger pin edge sets counter-on
// RULE20: pulse ends by software or A match
// RULE21: single pulse counter zeroed only on start
// RULE22: compare-P meets counter bits 9..7
// RULE23: rise clears counter, fall keeps value
// RULE24: action 01 low, 10 high, 11 toggle
// RULE25: invert bit flips pin, not timer mode
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stm_timer
  import stm_pkg::*;
(
  // clock, reset, enable
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_B,
  input  wire logic                   I_CE,
  // register port
  input  wire logic [`STM_ADDR_W-1:0] I_ADDR,
  input  wire logic [`STM_DATA_W-1:0] I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic      [`STM_DATA_W-1:0] O_RDATA,
  // pins
  input  wire logic                   I_EXT_CLK,
  output logic                        O_TM_OUT,
  output logic                        O_TM_OE,
  // flag levels
  output logic                        O_FLAG_A,
  output logic                        O_FLAG_P
);

  tm_state_t st_r;
  tm_state_t st_nxt;

  logic ext_rise;
  logic match_a;
  logic match_p;
  logic pwm_wrap;
  logic pwm_active;
  logic pwm_full;
  logic on_rise;
  logic single;
  logic set_a;
  logic set_p;
  logic clr_a;
  logic clr_p;
  logic wr_c0;
  logic active;

  stm_edge_sync u_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_ce    (I_CE),
    .i_pin   (I_EXT_CLK),
    .o_rise  (ext_rise)
  );

  stm_match_unit u_match (
    .i_cnt        (st_r.cnt),
    .i_cmpa       (st_r.cmpa),
    .i_cmpp       (st_r.cmpp),
    .i_dpx        (st_r.dpx),
    .o_match_a    (match_a),
    .o_match_p    (match_p),
    .o_pwm_wrap   (pwm_wrap),
    .o_pwm_active (pwm_active),
    .o_pwm_full   (pwm_full)
  );

  // register read mux
  function automatic logic [`STM_DATA_W-1:0] read_mux(input tm_state_t s,
                                                      input logic [`STM_ADDR_W-1:0] a);
    logic [`STM_DATA_W-1:0] d;
    d = `STM_RST_BYTE;
    case (a)
      `STM_OFS_CTRL0: begin
        d[`STM_C0_ON]                  = s.on;
        d[`STM_C0_P_HI:`STM_C0_P_LO]   = s.cmpp;
      end
      `STM_OFS_CTRL1: begin
        d[`STM_C1_MODE_HI:`STM_C1_MODE_LO] = s.mode;
        d[`STM_C1_IO_HI:`STM_C1_IO_LO]     = s.io;
        d[`STM_C1_OC]                      = s.oc;
        d[`STM_C1_POL]                     = s.pol;
        d[`STM_C1_DPX]                     = s.dpx;
        d[`STM_C1_CCLR]                    = s.cclr;
      end
      `STM_OFS_CNT_LO:  d = s.cnt[7:0];  // RULE1
      `STM_OFS_CNT_HI:  d[1:0] = s.cnt[9:8];  // RULE1
      `STM_OFS_CMPA_LO: d = s.cmpa[7:0];  // RULE2
      `STM_OFS_CMPA_HI: d[1:0] = s.cmpa[9:8];  // RULE2
      `STM_OFS_FLAGS: begin
        d[`STM_FL_A] = s.flag_a;
        d[`STM_FL_P] = s.flag_p;
      end
      default: d = `STM_RST_BYTE;
    endcase
    read_mux = d;
  endfunction : read_mux

  always_comb begin
    st_nxt  = st_r;
    on_rise = st_r.on && !st_r.on_d;
    single  = (st_r.mode == MODE_PWM) && (st_r.io == `STM_IO_PULSE);  // RULE18
    set_a   = 1'b0;
    set_p   = 1'b0;
    active  = 1'b0;
    wr_c0   = I_WR && (I_ADDR == `STM_OFS_CTRL0);
    clr_a   = I_WR && (I_ADDR == `STM_OFS_FLAGS) && I_WDATA[`STM_FL_A];
    clr_p   = I_WR && (I_ADDR == `STM_OFS_FLAGS) && I_WDATA[`STM_FL_P];

    st_nxt.on_d  = st_r.on;
    st_nxt.rdata = I_RD ? read_mux(st_r, I_ADDR) : `STM_RST_BYTE;

    // register writes
    if (wr_c0) begin
      st_nxt.on   = I_WDATA[`STM_C0_ON];
      st_nxt.cmpp = I_WDATA[`STM_C0_P_HI:`STM_C0_P_LO];
    end
    if (I_WR && (I_ADDR == `STM_OFS_CTRL1)) begin
      st_nxt.mode = tm_mode_t'(I_WDATA[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);
      st_nxt.io   = I_WDATA[`STM_C1_IO_HI:`STM_C1_IO_LO];
      st_nxt.oc   = I_WDATA[`STM_C1_OC];
      st_nxt.pol  = I_WDATA[`STM_C1_POL];
      st_nxt.dpx  = I_WDATA[`STM_C1_DPX];
      st_nxt.cclr = I_WDATA[`STM_C1_CCLR];
    end
    if (I_WR && (I_ADDR == `STM_OFS_CMPA_LO)) begin
      st_nxt.cmpa[7:0] = I_WDATA;  // RULE2
    end
    if (I_WR && (I_ADDR == `STM_OFS_CMPA_HI)) begin
      st_nxt.cmpa[9:8] = I_WDATA[1:0];  // RULE2
    end

    // trigger pin starts the pulse like a software write
    if (single && ext_rise && !st_r.on) begin
      st_nxt.on = 1'b1;  // RULE19
    end

    // counter
    if (on_rise) begin
      st_nxt.cnt = `STM_CNT_ZERO;  // RULE23 RULE21
      if (st_r.mode == MODE_COMPARE) begin
        st_nxt.lvl = st_r.oc;  // RULE9
      end
    end else if (st_r.on) begin
      case (st_r.mode)
        MODE_COMPARE, MODE_TIMER: begin
          // overflow wraps 3ff to zero on its own
          if (st_r.cclr) begin
            st_nxt.cnt = match_a ? `STM_CNT_ZERO : st_r.cnt + `STM_CNT_ONE;  // RULE5 RULE3
            set_a      = match_a;  // RULE5
          end else begin
            st_nxt.cnt = match_p ? `STM_CNT_ZERO : st_r.cnt + `STM_CNT_ONE;  // RULE4 RULE3
            set_a      = match_a;  // RULE4
            set_p      = match_p;  // RULE4
          end
          // pin follows only the A flag
          if (set_a && (st_r.mode == MODE_COMPARE)) begin
            case (st_r.io)
              `STM_IO_LOW:    st_nxt.lvl = 1'b0;  // RULE24 RULE8
              `STM_IO_HIGH:   st_nxt.lvl = 1'b1;  // RULE24 RULE8
              `STM_IO_TOGGLE: st_nxt.lvl = !st_r.lvl;  // RULE24 RULE8
              default:        st_nxt.lvl = st_r.lvl;  // RULE8
            endcase
          end
        end
        MODE_PWM: begin
          if (single) begin
            // counter free-runs; only a new start zeroes it
            st_nxt.cnt = st_r.cnt + `STM_CNT_ONE;  // RULE21
            if (match_a) begin
              set_a     = 1'b1;  // RULE20
              st_nxt.on = 1'b0;  // RULE20
            end
          end else begin
            st_nxt.cnt = pwm_wrap ? `STM_CNT_ZERO : st_r.cnt + `STM_CNT_ONE;  // RULE17
            set_a      = match_a;  // RULE15
            set_p      = match_p;  // RULE15
          end
        end
        default: begin
          // capture input is not built: counter runs, cleared by P
          st_nxt.cnt = match_p ? `STM_CNT_ZERO : st_r.cnt + `STM_CNT_ONE;
          set_p      = match_p;
        end
      endcase
    end

    // sticky flags, a new event wins over a clear
    st_nxt.flag_a = (st_r.flag_a && !clr_a) || set_a;
    st_nxt.flag_p = (st_r.flag_p && !clr_p) || set_p;

    // output pin
    case (st_r.mode)
      MODE_COMPARE: begin
        st_nxt.oe  = 1'b1;
        st_nxt.pin = st_nxt.lvl ^ st_r.pol;  // RULE25
      end
      MODE_PWM: begin
        st_nxt.oe = 1'b1;
        if (single) begin
          active = st_nxt.on;  // RULE18 RULE20
        end else begin
          case (st_r.io)
            `STM_IO_NONE: active = 1'b0;  // RULE16
            `STM_IO_LOW:  active = 1'b1;  // RULE16
            default:      active = pwm_active;  // RULE12 RULE13 RULE14
          endcase
        end
        // oc selects active-high, invert flips the whole waveform
        st_nxt.pin = (active ? st_r.oc : !st_r.oc) ^ st_r.pol;  // RULE16 RULE25
      end
      default: begin
        st_nxt.oe  = 1'b0;  // RULE10
        st_nxt.pin = 1'b0;  // RULE10
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_r <= '0;
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  assign O_RDATA  = st_r.rdata;
  assign O_TM_OUT = st_r.pin;
  assign O_TM_OE  = st_r.oe;
  assign O_FLAG_A = st_r.flag_a;
  assign O_FLAG_P = st_r.flag_p;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  chk_cnt_hi_read: assert property ( // RULE1
    I_CE && I_RD && (I_ADDR == `STM_OFS_CNT_HI)
      |=> (O_RDATA[7:2] == 6'h00) && (O_RDATA[1:0] == $past(st_r.cnt[9:8])))
    else $error("counter high read wrong");

  chk_cmpa_write: assert property ( // RULE2
    I_CE && I_WR && (I_ADDR == `STM_OFS_CMPA_LO)
      |=> st_r.cmpa[7:0] == $past(I_WDATA))
    else $error("compare-A low byte not stored");

  chk_on_rise_zero: assert property ( // RULE23
    I_CE && st_r.on && !st_r.on_d |=> st_r.cnt == `STM_CNT_ZERO)
    else $error("counter not zeroed at start");

  chk_off_holds_cnt: assert property ( // RULE23
    I_CE && !st_r.on && !st_r.on_d |=> st_r.cnt == $past(st_r.cnt))
    else $error("stopped counter moved");

  chk_no_p_flag: assert property ( // RULE5
    I_CE && st_r.on && (st_r.mode == MODE_COMPARE) && st_r.cclr && !st_r.flag_p
      |=> !st_r.flag_p)
    else $error("P flag raised with clear-select high");

  chk_zero_a_flag: assert property ( // RULE6
    I_CE && (st_r.cmpa == `STM_CNT_ZERO) && (st_r.mode != MODE_CAPTURE) && !st_r.flag_a
      |=> !st_r.flag_a)
    else $error("A flag raised with zero compare-A");

  chk_a_clear: assert property ( // RULE3
    I_CE && st_r.on && st_r.on_d && (st_r.mode == MODE_COMPARE) && st_r.cclr && match_a
      |=> (st_r.cnt == `STM_CNT_ZERO) && st_r.flag_a)
    else $error("A match did not clear counter");

  chk_pulse_end: assert property ( // RULE20
    I_CE && single && st_r.on && st_r.on_d && match_a
      |=> !st_r.on && st_r.flag_a && (O_TM_OUT == $past(!st_r.oc ^ st_r.pol)))
    else $error("single pulse did not end on A match");

  chk_trigger_start: assert property ( // RULE19
    I_CE && single && ext_rise && !st_r.on
      |=> st_r.on ##1 (!$past(I_CE) || (st_r.cnt == `STM_CNT_ZERO)))
    else $error("trigger pin did not start pulse");

  chk_pwm_full: assert property ( // RULE14
    I_CE && (st_r.mode == MODE_PWM) && (st_r.io == `STM_IO_PWM) && pwm_full
      |=> O_TM_OUT == $past(st_r.oc ^ st_r.pol))
    else $error("full duty not held active");

  chk_timer_pin: assert property ( // RULE10
    I_CE && (st_r.mode == MODE_TIMER) |=> !O_TM_OE && !O_TM_OUT)
    else $error("pin driven in timer mode");

  chk_cnt_lo_read: assert property ( // RULE1
    I_CE && I_RD && (I_ADDR == `STM_OFS_CNT_LO)
      |=> O_RDATA == $past(st_r.cnt[7:0]))
    else $error("counter low read wrong");

  chk_cmpa_hi_write: assert property ( // RULE2
    I_CE && I_WR && (I_ADDR == `STM_OFS_CMPA_HI)
      |=> st_r.cmpa[9:8] == $past(I_WDATA[1:0]))
    else $error("compare-A high bits not stored");

  chk_p_clear: assert property ( // RULE4
    I_CE && st_r.on && st_r.on_d && (st_r.mode == MODE_COMPARE) && !st_r.cclr && match_p
      |=> (st_r.cnt == `STM_CNT_ZERO) && st_r.flag_p)
    else $error("P match did not clear counter");

  chk_pin_on_rise: assert property ( // RULE9
    I_CE && st_r.on && !st_r.on_d && (st_r.mode == MODE_COMPARE)
      |=> O_TM_OUT == $past(st_r.oc ^ st_r.pol))
    else $error("pin not at initial level after start");

  chk_lvl_a_only: assert property ( // RULE8
    I_CE && st_r.on && st_r.on_d && (st_r.mode == MODE_COMPARE) && !match_a
      |=> st_r.lvl == $past(st_r.lvl))
    else $error("pin level moved without A match");

  chk_toggle_a: assert property ( // RULE24
    I_CE && st_r.on && st_r.on_d && (st_r.mode == MODE_COMPARE) && match_a
      && (st_r.io == `STM_IO_TOGGLE) |=> st_r.lvl != $past(st_r.lvl))
    else $error("toggle action did not toggle");

  chk_pwm_wrap: assert property ( // RULE17
    I_CE && st_r.on && st_r.on_d && (st_r.mode == MODE_PWM) && !single && pwm_wrap
      |=> st_r.cnt == `STM_CNT_ZERO)
    else $error("pwm period did not clear counter");

  chk_pwm_force: assert property ( // RULE16
    I_CE && (st_r.mode == MODE_PWM) && (st_r.io == `STM_IO_NONE)
      |=> O_TM_OUT == $past(!st_r.oc ^ st_r.pol))
    else $error("forced inactive level wrong");

  chk_single_run: assert property ( // RULE21
    I_CE && single && st_r.on && st_r.on_d
      |=> st_r.cnt == $past(st_r.cnt) + `STM_CNT_ONE)
    else $error("single pulse counter cleared while running");

endmodule : stm_timer
`default_nettype wire

//--- dv/stm_pin_load.sv
// external load on the timer output pin and trigger source on the clock pin
// assumes: one clock; the wire has a pull-down while the timer does not drive it
`timescale 1ns/1ps
`default_nettype none
module stm_pin_load (
  // clock and command
  input  wire logic i_clk,
  input  wire logic i_fire,
  // timer pins
  input  wire logic i_pin,
  input  wire logic i_oe,
  output logic      o_ext_clk,
  // observations
  output logic      o_level,
  output int        o_width,
  output int        o_pulses
);
  int run;
  int hold;

  // undriven wire falls to the pull-down level
  assign o_level = i_oe ? i_pin : 1'b0;

  initial begin
    o_ext_clk = 1'b0;
    o_width   = 0;
    o_pulses  = 0;
    run       = 0;
    hold      = 0;
  end

  // trigger edge held four cycles, low between triggers
  always @(posedge i_clk) begin
    if (i_fire) begin
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
    o_ext_clk <= i_fire || (hold > 1);
  end

  // width of each high pulse seen on the wire
  always @(posedge i_clk) begin
    if (o_level === 1'b1) begin
      run <= run + 1;
    end else if (run > 0) begin
      o_width  <= run;
      o_pulses <= o_pulses + 1;
      run      <= 0;
    end
  end
endmodule : stm_pin_load
`default_nettype wire

//--- dv/standard_timer_compare_pwm_pulse_bench.sv
// self-checking bench of the standard timer: registers, compare, timer, pwm, single pulse
// assumes: rtl/stm_pkg.sv and rtl/stm_timer.sv compiled first, stm_map.svh on include path
`timescale 1ns/1ps
`default_nettype none
`include "stm_map.svh"
module standard_timer_compare_pwm_pulse_bench;
  import stm_pkg::*;

  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic       w;
    logic [7:0] e;
  } row_t;

  typedef struct packed {
    logic [7:0] c1;
    logic [9:0] a;
    logic [2:0] p;
    logic [8:0] win;
    logic [8:0] hi;
    logic [1:0] fl;
    logic [1:0] fm;
  } pwm_t;

  logic       clk;
  logic       rst_b;
  logic       ce;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic       ext_clk;
  logic       tm_out;
  logic       tm_oe;
  logic       flag_a;
  logic       flag_p;
  logic       fire;
  logic       level;
  int         width;
  int         pulses;
  int         fails;
  int         comparisons;
  int         cyc;
  int         k;
  int         n0;
  logic [7:0] v;
  logic [7:0] v2;

  // register rows: address, write data, write first, expected read
  row_t rows [9] = '{
    '{`STM_OFS_CNT_LO, 8'h00, 1'b0, 8'h00}, '{`STM_OFS_CNT_HI, 8'h00, 1'b0, 8'h00},
    '{`STM_OFS_CMPA_LO, 8'h00, 1'b0, 8'h00}, '{`STM_OFS_CMPA_HI, 8'h00, 1'b0, 8'h00},
    '{`STM_OFS_CMPA_LO, 8'ha5, 1'b1, 8'ha5}, '{`STM_OFS_CMPA_HI, 8'hff, 1'b1, 8'h03},
    '{`STM_OFS_CNT_LO, 8'h77, 1'b1, 8'h00}, '{`STM_OFS_CNT_HI, 8'hff, 1'b1, 8'h00},
    '{3'h7, 8'hff, 1'b1, 8'h00}};

  // pwm rows: control one, compare-A, compare-P, window, high cycles, flags {p,a}, flag mask
  pwm_t pw [7] = '{
    '{8'ha8, 10'h020, 3'h1, 9'h080, 9'h020, 2'b01, 2'b01},
    '{8'ha8, 10'h0c8, 3'h1, 9'h080, 9'h080, 2'b00, 2'b01},
    '{8'hac, 10'h020, 3'h1, 9'h080, 9'h060, 2'b01, 2'b01},
    '{8'haa, 10'h12c, 3'h1, 9'h12c, 9'h080, 2'b10, 2'b10},
    '{8'h88, 10'h020, 3'h1, 9'h080, 9'h000, 2'b01, 2'b01},
    '{8'h98, 10'h020, 3'h1, 9'h080, 9'h080, 2'b01, 2'b01},
    '{8'ha9, 10'h020, 3'h1, 9'h080, 9'h020, 2'b01, 2'b01}};

  stm_timer stm_timer_inst (
    .I_CLK     (clk),
    .I_RST_B   (rst_b),
    .I_CE      (ce),
    .I_ADDR    (addr),
    .I_WDATA   (wdata),
    .I_WR      (wr_s),
    .I_RD      (rd_s),
    .O_RDATA   (rdata),
    .I_EXT_CLK (ext_clk),
    .O_TM_OUT  (tm_out),
    .O_TM_OE   (tm_oe),
    .O_FLAG_A  (flag_a),
    .O_FLAG_P  (flag_p)
  );

  stm_pin_load stm_pin_load_inst (
    .i_clk     (clk),
    .i_fire    (fire),
    .i_pin     (tm_out),
    .i_oe      (tm_oe),
    .o_ext_clk (ext_clk),
    .o_level   (level),
    .o_width   (width),
    .o_pulses  (pulses)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  // stop, clear flags, load compare values and control, then start if asked
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p,
                     input logic on);
    wr(`STM_OFS_CTRL0, 8'h00);
    wr(`STM_OFS_FLAGS, 8'h03);
    wr(`STM_OFS_CMPA_LO, a[7:0]);
    wr(`STM_OFS_CMPA_HI, {6'h00, a[9:8]});
    wr(`STM_OFS_CTRL1, c1);
    wr(`STM_OFS_CTRL0, {4'h0, on, p});
  endtask : cfg

  task automatic count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1 c = c + ((level === 1'b1) ? 1 : 0);
    end
  endtask : count_high

  task results;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // hang guard well above the planned run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      results();
    end
  end

  initial begin
    fails = 0;
    comparisons = 0;
    cyc = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    fire = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("reg_read", {3'h0, rows[i].e}, {3'h0, v});
    end
    // action low from initial high, then high from low, then none
    cfg(8'h19, 10'd50, 3'h0, 1'b1);
    wait_n(4);
    chk("pin_init_high", 11'h1, {10'h0, level});
    wait_n(60);
    chk("pin_low", 11'h0, {10'h0, level});
    cfg(8'h21, 10'd300, 3'h1, 1'b1);
    wait_n(700);
    chk("flag_a", 11'h1, {10'h0, flag_a});
    chk("flag_p", 11'h0, {10'h0, flag_p});
    chk("pin_high", 11'h1, {10'h0, level});
    cfg(8'h01, 10'd3, 3'h0, 1'b1);
    wait_n(20);
    chk("pin_none", 11'h0, {10'h0, level});
    chk("flag_a_none", 11'h1, {10'h0, flag_a});
    cfg(8'h39, 10'd3, 3'h0, 1'b1);
    wait_n(10);
    k = 0;
    v[0] = level;
    repeat (40) begin
      @(posedge clk);
      #1 k = k + ((level !== v[0]) ? 1 : 0);
      v[0] = level;
    end
    chk("toggles", 11'd10, 11'(k));
    // clear on comparator P, both flags
    cfg(8'h20, 10'd16, 3'h1, 1'b1);
    wait_n(140);
    chk("flags_both", 11'h3, {9'h0, flag_p, flag_a});
    rd(`STM_OFS_CNT_LO, v);
    chk("cnt_below_128", 11'h0, {3'h0, v & 8'h80});
    cfg(8'he1, 10'd0, 3'h0, 1'b1);
    wait_n(1100);
    chk("flag_a_zero", 11'h0, {10'h0, flag_a});
    cfg(8'hf9, 10'd3, 3'h1, 1'b1);
    wait_n(140);
    chk("timer_flags", 11'h1, {9'h0, flag_p, flag_a});
    chk("timer_oe", 11'h0, {10'h0, tm_oe});
    cfg(8'h40, 10'd3, 3'h1, 1'b1);
    wait_n(140);
    chk("capture_p", 11'h2, {8'h0, tm_oe, flag_p, flag_a});
    foreach (pw[i]) begin
      cfg(pw[i].c1, pw[i].a, pw[i].p, 1'b1);
      wait_n(2 * int'(pw[i].win));
      count_high(int'(pw[i].win), k);
      chk("pwm_high", {2'h0, pw[i].hi}, 11'(k));
      chk("pwm_flags", {9'h0, pw[i].fl}, {9'h0, {flag_p, flag_a} & pw[i].fm});
    end
    // single pulse: pin trigger, compare-A end, software start and abort
    cfg(8'hb8, 10'd20, 3'h5, 1'b0);
    wait_n(4);
    n0 = pulses;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_n(60);
    chk("pulse_count", 11'h1, 11'(pulses - n0));
    chk("pulse_width", 11'h1, {10'h0, (width >= 19 && width <= 22)});
    chk("pulse_flag_a", 11'h1, {10'h0, flag_a});
    rd(`STM_OFS_CTRL0, v);
    chk("on_cleared", 11'h0, {10'h0, v[3]});
    rd(`STM_OFS_CNT_LO, v);
    rd(`STM_OFS_CNT_LO, v2);
    chk("cnt_held", {3'h0, v}, {3'h0, v2});
    wr(`STM_OFS_CTRL0, 8'h08);
    wait_n(3);
    rd(`STM_OFS_CNT_LO, v);
    chk("cnt_restart", 11'h1, {10'h0, v < 8'h0a});
    wait_n(60);
    chk("pulse_count_sw", 11'h2, 11'(pulses - n0));
    wr(`STM_OFS_CTRL0, 8'h08);
    wait_n(6);
    wr(`STM_OFS_CTRL0, 8'h00);
    wait_n(40);
    chk("pulse_abort", 11'h1, {10'h0, (width < 19)});
    chk("pulse_count_abort", 11'h3, 11'(pulses - n0));
    // reset in mid-run returns registers to zero
    rst_b <= 1'b0;
    wait_n(3);
    rst_b <= 1'b1;
    rd(`STM_OFS_CMPA_LO, v);
    chk("reset_cmpa", 11'h0, {3'h0, v});
    rd(`STM_OFS_CNT_LO, v);
    chk("reset_cnt", 11'h0, {3'h0, v});
    results();
  end
endmodule : standard_timer_compare_pwm_pulse_bench
`default_nettype wire
